// *** logic/osrs_top.sv ***
// osrs_top: session request control/status register with sticky flags
// assumes: microprocessor register port on mclk; line and supply senses from pins
`default_nettype none

module osrs_top
  import osrs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire osrs_req_t   regReq,
  output var  logic [7:0]  regRdData,
  input  wire osrs_sense_t senseIn,
  input  wire logic        pullupConnect,
  output var  logic        posLineOut,
  output var  logic        posLineOe,
  output var  logic        pullupOn,
  output var  logic        vbusPulseOn,
  output var  logic        vbusDischargeOn
);

  osrs_sense_t senseSync;
  logic [7:0]  ctrl_q;
  logic        sessValid_q;
  logic        initViol_q;
  logic        wrHit;
  logic        enable;
  logic        setSess;
  logic        setViol;
  logic        clrSess;
  logic        clrViol;
  logic        lineSe0;

  // pins are asynchronous; nothing reads them before two flops
  osrs_sync #(
    .W ($bits(osrs_sense_t))
  ) u_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn (senseIn),
    .syncOut (senseSync)
  );

  assign wrHit   = regReq.wrEn && (regReq.addr == OSRS_REG_ADDR);
  assign enable  = ctrl_q[OSRS_BIT_ENABLE];
  assign lineSe0 = !senseSync.lineHigh && !senseSync.negLineHigh;

  // status only tracked while a request is enabled; otherwise left alone
  assign setSess = enable && senseSync.sessionAbove;
  assign setViol = enable && (!senseSync.vbusBelowLow || !lineSe0);
  assign clrSess = wrHit && regReq.wrData[OSRS_BIT_SESSVAL];
  assign clrViol = wrHit && regReq.wrData[OSRS_BIT_INITVIOL];

  // control bits: plain read/write, reserved and flag bits excluded by mask
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= OSRS_CTRL_RESET;
    end else if (wrHit) begin
      ctrl_q <= regReq.wrData & OSRS_CTRL_MASK;
    end
  end

  // set wins over a same-cycle clear so a live session is never lost
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sessValid_q <= 1'b0;
    end else begin
      sessValid_q <= (sessValid_q && !clrSess) || setSess;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      initViol_q <= 1'b0;
    end else begin
      initViol_q <= (initViol_q && !clrViol) || setViol;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= {2'b00, ctrl_q[OSRS_BIT_DLPULSE], sessValid_q, initViol_q,
                    ctrl_q[OSRS_BIT_DISCH:OSRS_BIT_ENABLE]};
    end
  end

  // outputs from flops; pulse and supply controls masked while request disabled, pull-up follows pullupConnect
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      posLineOut      <= 1'b0;
      posLineOe       <= 1'b0;
      pullupOn        <= 1'b0;
      vbusPulseOn     <= 1'b0;
      vbusDischargeOn <= 1'b0;
    end else begin
      posLineOut      <= 1'b1;
      posLineOe       <= enable && ctrl_q[OSRS_BIT_DLPULSE];
      pullupOn        <= pullupConnect;
      vbusPulseOn     <= enable && ctrl_q[OSRS_BIT_VPULSE];
      vbusDischargeOn <= enable && ctrl_q[OSRS_BIT_DISCH];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pulse_drive: assert property (
    wrHit && regReq.wrData[OSRS_BIT_DLPULSE] && regReq.wrData[OSRS_BIT_ENABLE]
      |=> ##1 posLineOe)
    else $error("pulse bit written but line not driven");
  a_disabled_quiet: assert property (
    wrHit && !regReq.wrData[OSRS_BIT_ENABLE] |=> ##1 !posLineOe && !vbusPulseOn)
    else $error("controls active while request disabled");
  a_sess_set: assert property (
    setSess |=> sessValid_q)
    else $error("session flag not set on valid session");
  a_sess_hold: assert property (
    sessValid_q && !clrSess |=> sessValid_q)
    else $error("session flag dropped without clear");
  a_sess_clear: assert property (
    clrSess && !setSess |=> !sessValid_q)
    else $error("session flag not cleared by write 1");
  a_viol_set: assert property (
    setViol |=> initViol_q)
    else $error("violation flag not set");
  a_viol_clear: assert property (
    clrViol && !setViol |=> !initViol_q)
    else $error("violation flag not cleared by write 1");
  a_read_flags: assert property (
    ##1 regRdData == {2'b00, $past(ctrl_q[OSRS_BIT_DLPULSE]), $past(sessValid_q),
                      $past(initViol_q), $past(ctrl_q[OSRS_BIT_DISCH:OSRS_BIT_ENABLE])})
    else $error("read data mismatch");
  a_pullup: assert property (
    pullupConnect |=> pullupOn)
    else $error("pull-up not connected");

  // line drive and masking of the controls
  a_pulse_release: assert property (
    wrHit && !regReq.wrData[OSRS_BIT_DLPULSE]
      |=> ##1 !posLineOe)
    else $error("line still driven after pulse bit cleared");
  a_line_high: assert property (
    posLineOe
      |-> posLineOut)
    else $error("pulse drives line low");
  a_vbus_masked: assert property (
    !enable
      |=> !vbusPulseOn && !vbusDischargeOn)
    else $error("supply controls active while disabled");
  a_pullup_drop: assert property (
    !pullupConnect
      |=> !pullupOn)
    else $error("pull-up stays on after disconnect");

  // register port: foreign writes and reserved bits
  a_foreign_write: assert property (
    !wrHit
      |=> $stable(ctrl_q))
    else $error("control bits changed without a write");
  a_reserved_zero: assert property (
    regRdData[7:6] == 2'h0)
    else $error("reserved bits read nonzero");

  // sticky flags: races, holds, masking and read-back; sense sync depth
  a_sess_race: assert property (
    clrSess && setSess
      |=> sessValid_q)
    else $error("clear beat a live session");
  a_viol_hold: assert property (
    initViol_q && !clrViol
      |=> initViol_q)
    else $error("violation flag dropped without clear");
  a_viol_race: assert property (
    clrViol && setViol
      |=> initViol_q)
    else $error("clear beat a live violation");
  a_sess_masked: assert property (
    !enable && !sessValid_q
      |=> !sessValid_q)
    else $error("session flag set while disabled");
  a_viol_masked: assert property (
    !enable && !initViol_q
      |=> !initViol_q)
    else $error("violation flag set while disabled");
  a_sess_read: assert property (
    sessValid_q
      |=> regRdData[OSRS_BIT_SESSVAL])
    else $error("session flag not visible on read");
  a_viol_read: assert property (
    initViol_q
      |=> regRdData[OSRS_BIT_INITVIOL])
    else $error("violation flag not visible on read");
  a_sync_delay: assert property (
    $past(rst_b, 2)
      |-> senseSync == $past(senseIn, 2))
    else $error("sense path not two flops deep");

  c_sess_seen:  cover property (setSess ##1 sessValid_q);
  c_viol_race:  cover property (clrViol && setViol);
  c_clr_race:   cover property (clrSess && setSess);
  c_viol_clean: cover property (clrViol ##1 !initViol_q [*8]);
  c_pulse:      cover property ($rose(posLineOe) ##[1:20] $fell(posLineOe));

endmodule : osrs_top

`default_nettype wire

// *** logic/osrs_pkg.sv ***
// osrs_pkg: constants and types for the session request control and status block
// assumes: one 100 MHz device clock, 8-bit parallel register port
`default_nettype none

package osrs_pkg;

  localparam logic [7:0] OSRS_REG_ADDR     = 8'h12;
  localparam int         OSRS_BIT_ENABLE   = 0;
  localparam int         OSRS_BIT_VPULSE   = 1;
  localparam int         OSRS_BIT_DISCH    = 2;
  localparam int         OSRS_BIT_INITVIOL = 3;
  localparam int         OSRS_BIT_SESSVAL  = 4;
  localparam int         OSRS_BIT_DLPULSE  = 5;
  localparam logic [7:0] OSRS_CTRL_MASK    = 8'h27;
  localparam logic [7:0] OSRS_CTRL_RESET   = 8'h00;
  localparam int         OSRS_SYNC_STAGES  = 2;

  // sampled analog/line conditions, as seen from the pins
  typedef struct packed {
    logic sessionAbove;
    logic vbusBelowLow;
    logic lineHigh;
    logic negLineHigh;
  } osrs_sense_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic [7:0] wrData;
  } osrs_req_t;

endpackage : osrs_pkg

`default_nettype wire

// *** logic/osrs_sync.sv ***
// osrs_sync: two-flop synchroniser, one chain per bit
// assumes: inputs are asynchronous to mclk; first stage read by second only
`default_nettype none

module osrs_sync
  import osrs_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        stage1_q[i] <= 1'b0;
        syncOut[i]  <= 1'b0;
      end else begin
        stage1_q[i] <= asyncIn[i];
        syncOut[i]  <= stage1_q[i];
      end
    end
  end

endmodule : osrs_sync

`default_nettype wire

// *** tb/osrs_line_model.sv ***
// osrs_line_model: cable and far-side host as seen by the sense pins
// assumes: bench sets supply and line states; device drive on the line is folded in
`default_nettype none

module osrs_line_model
  import osrs_pkg::*;
(
  input  wire logic  sessOn,
  input  wire logic  lineBad,
  input  wire logic  posLineOut,
  input  wire logic  posLineOe,
  output var  osrs_sense_t senseOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // supply is either above the session threshold or discharged below 0.8 V
  always_comb begin
    senseOut.sessionAbove = sessOn;
    senseOut.vbusBelowLow = !sessOn;
    senseOut.lineHigh     = lineBad | (posLineOe & posLineOut);
    senseOut.negLineHigh  = 1'b0;
  end
endmodule : osrs_line_model

`default_nettype wire

// *** tb/osrs_top_tb.sv ***
// osrs_top_tb: register-level tests of the session request block
// assumes: osrs_top and osrs_line_model compiled first
`default_nettype none

module osrs_top_tb;
  import osrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, rst_b = 0, pullupConnect = 0, sessOn = 0, lineBad = 0;
  osrs_req_t   regReq = '0;
  osrs_sense_t senseIn;
  logic [7:0]  regRdData;
  logic        posLineOut, posLineOe, pullupOn, vbusPulseOn, vbusDischargeOn;
  int          failures = 0, tests_run = 0;

  always #5 mclk = ~mclk;

  osrs_top dut_u (.mclk(mclk), .rst_b(rst_b), .regReq(regReq), .regRdData(regRdData),
    .senseIn(senseIn), .pullupConnect(pullupConnect), .posLineOut(posLineOut),
    .posLineOe(posLineOe), .pullupOn(pullupOn), .vbusPulseOn(vbusPulseOn),
    .vbusDischargeOn(vbusDischargeOn));
  osrs_line_model line_u (.sessOn(sessOn), .lineBad(lineBad), .posLineOut(posLineOut),
    .posLineOe(posLineOe), .senseOut(senseIn));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regReq <= '{a, 1'b1, d};
    @(posedge mclk);
    regReq.wrEn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr

  // waits out two sync stages, the flag update and the read lag
  task automatic sense(input logic s, input logic b);
    @(posedge mclk);
    sessOn  <= s;
    lineBad <= b;
    repeat (6) @(posedge mclk);
    #1;
  endtask : sense

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2000) @(posedge mclk);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(regRdData, 8'h00);
    chk({6'h00, posLineOe, pullupOn}, 8'h00);
    wr(OSRS_REG_ADDR, 8'he1);
    chk(regRdData, 8'h21);
    chk({6'h00, posLineOe, posLineOut}, 8'h03);
    // firmware waits scaled down; the block itself keeps no timers
    repeat (8) @(posedge mclk);
    wr(OSRS_REG_ADDR, 8'h01);
    chk({7'h00, posLineOe}, 8'h00);
    wr(8'h34, 8'h27);
    // the driven pulse itself breaks SE0, so the violation flag is up
    chk(regRdData, 8'h09);
    $display("test control bits done");
    repeat (20) @(posedge mclk);
    sense(1'b1, 1'b0);
    chk(regRdData, 8'h19);
    wr(OSRS_REG_ADDR, 8'h11);
    chk(regRdData, 8'h19);
    sense(1'b0, 1'b0);
    chk(regRdData, 8'h19);
    wr(OSRS_REG_ADDR, 8'h05);
    chk({6'h00, vbusPulseOn, vbusDischargeOn}, 8'h01);
    wr(OSRS_REG_ADDR, 8'h19);
    chk(regRdData, 8'h01);
    $display("test session flag done");
    sense(1'b0, 1'b1);
    chk(regRdData, 8'h09);
    sense(1'b0, 1'b0);
    wr(OSRS_REG_ADDR, 8'h01);
    chk(regRdData, 8'h09);
    wr(OSRS_REG_ADDR, 8'h09);
    repeat (20) @(posedge mclk);
    #1 chk(regRdData, 8'h01);
    sense(1'b0, 1'b1);
    chk(regRdData, 8'h09);
    // enable still high at the abandoning write, so the live set wins
    wr(OSRS_REG_ADDR, 8'h08);
    chk(regRdData, 8'h08);
    wr(OSRS_REG_ADDR, 8'h08);
    chk(regRdData, 8'h00);
    $display("test violation flag done");
    sense(1'b0, 1'b0);
    wr(OSRS_REG_ADDR, 8'h07);
    chk({6'h00, vbusPulseOn, vbusDischargeOn}, 8'h03);
    wr(OSRS_REG_ADDR, 8'h06);
    chk({6'h00, vbusPulseOn, vbusDischargeOn}, 8'h00);
    wr(OSRS_REG_ADDR, 8'h01);
    sense(1'b1, 1'b0);
    chk(regRdData, 8'h19);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(regRdData, 8'h00);
    chk({7'h00, pullupOn}, 8'h00);
    @(posedge mclk);
    pullupConnect <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, pullupOn}, 8'h01);
    $display("test reset and outputs done");
    end_of_test();
  end
endmodule : osrs_top_tb

`default_nettype wire
